// ==== verilog/pin_config.sv ====
/*
 pin_config: configuration and fault logic for general pins one and two,
 with an ahb-lite register slave and a level interrupt on fault events.
 assumes: one clock clk_sys, synchronous reset; pad cells outside take
 the pull and drive controls; fault reporting consumes fault_* outputs.
*/
// Chosen here: register access over AHB-Lite.
// Function
// - address select bit routes pin to addressing
// - direction bit: 0 output, 1 input
// - pull code 000: analog, no pulls
// - pull code 010: weak pull-up
// - pull code 100: weak pull-down, input only
// - pull code 101: push-pull, output only
// - fault field: never, low, high
// - registers at 0x2F and 0x30, same layout
// - pull field sits in bits 4:2
`timescale 1ns/1ns
`default_nettype none
module pin_config
    import pin_config_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pin one pad
    input wire logic pin_one_in,
    output logic pin_one_out,
    output logic pin_one_oe,
    output logic pin_one_pull_up,
    output logic pin_one_pull_down,
    output logic pin_one_analog,
    output logic pin_one_addr_use,
    // pin two pad
    input wire logic pin_two_in,
    output logic pin_two_out,
    output logic pin_two_oe,
    output logic pin_two_pull_up,
    output logic pin_two_pull_down,
    output logic pin_two_analog,
    output logic pin_two_addr_use,
    // drive levels and addressing
    input wire logic pin_one_drive,
    input wire logic pin_two_drive,
    output logic pin_one_addr_bit,
    output logic pin_two_addr_bit,
    // fault and interrupt
    output logic fault_pin_one,
    output logic fault_pin_two,
    output logic irq
);

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic wr_pend_r;
    logic [9:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic [7:0] pin_one_config_r;
    logic [7:0] pin_two_config_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_enable_r;
    logic [1:0] sync_a_r;
    logic [1:0] sync_b_r;
    logic [1:0] fault_r;
    logic [1:0] fault_q_r;
    logic [1:0] analog_r;
    logic [1:0] pull_up_r;
    logic [1:0] pull_down_r;
    logic [1:0] oe_r;
    logic [1:0] out_r;
    logic [1:0] addr_use_r;
    logic [1:0] addr_bit_r;

    wire logic [9:0] bus_addr = haddr[9:0];
    wire logic in_range = (haddr[31:10] == 22'h0);
    wire logic valid_xfer = hsel & hready & htrans[1];
    wire logic bus_wr = valid_xfer & hwrite & in_range;
    wire logic bus_rd = valid_xfer & ~hwrite;

    // ------------------------------------------------------------
    // write decode (data phase)
    // ------------------------------------------------------------
    // register address decode
    wire logic wr_one = wr_pend_r & (wr_addr_r == adr_pin_one_config);
    wire logic wr_two = wr_pend_r & (wr_addr_r == adr_pin_two_config);
    wire logic wr_en = wr_pend_r & (wr_addr_r == adr_irq_enable);
    wire logic wr_clr = wr_pend_r & (wr_addr_r == adr_irq_clear);

    // spare bit 7 is not stored and reads zero
    wire logic [7:0] cfg_wdata = {1'b0, hwdata[6:0]};

    // ------------------------------------------------------------
    // read mux (registered into data phase)
    // ------------------------------------------------------------
    wire logic [31:0] rd_mux =
        !in_range ? 32'h0 :
        (bus_addr == adr_pin_one_config) ? {24'h0, pin_one_config_r} :
        (bus_addr == adr_pin_two_config) ? {24'h0, pin_two_config_r} :
        (bus_addr == adr_irq_status) ? {30'h0, irq_status_r} :
        (bus_addr == adr_irq_enable) ? {30'h0, irq_enable_r} :
        (bus_addr == adr_pin_status) ? {28'h0, fault_r, sync_b_r} :
        32'h0;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 10'h0;
            rdata_r <= 32'h0;
        end
        else
        begin
            wr_pend_r <= bus_wr;
            wr_addr_r <= bus_addr;
            if (bus_rd)
                rdata_r <= rd_mux;
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_one_config_r <= rst_pin_config;
            pin_two_config_r <= rst_pin_config;
        end
        else
        begin
            if (wr_one)
                pin_one_config_r <= cfg_wdata;
            if (wr_two)
                pin_two_config_r <= cfg_wdata;
        end
    end

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    // pull field bits 4:2
    wire logic [2:0] pull_one = pin_one_config_r[pos_pull_hi:pos_pull_lo];
    wire logic [2:0] pull_two = pin_two_config_r[pos_pull_hi:pos_pull_lo];
    wire logic [1:0] flt_one = pin_one_config_r[pos_fault_hi:pos_fault_lo];
    wire logic [1:0] flt_two = pin_two_config_r[pos_fault_hi:pos_fault_lo];
    wire logic dir_one = pin_one_config_r[pos_dir_sel];
    wire logic dir_two = pin_two_config_r[pos_dir_sel];

    // ------------------------------------------------------------
    // pad control
    // ------------------------------------------------------------
    // analog mode, no pulls
    wire logic [1:0] analog_nxt = {pull_two == pull_analog,
        pull_one == pull_analog};
    wire logic [1:0] pull_up_nxt = {pull_two == pull_up_weak,
        pull_one == pull_up_weak};
    wire logic [1:0] pull_down_nxt = {(pull_two == pull_down_weak) & dir_two,
        (pull_one == pull_down_weak) & dir_one};
    wire logic [1:0] oe_nxt = {~dir_two & (pull_two == pull_push_pull),
        ~dir_one & (pull_one == pull_push_pull)};
    wire logic [1:0] out_nxt = {pin_two_drive, pin_one_drive} & oe_nxt;
    wire logic [1:0] addr_use_nxt = {pin_two_config_r[pos_addr_sel],
        pin_one_config_r[pos_addr_sel]};
    wire logic [1:0] addr_bit_nxt = addr_use_nxt & sync_b_r;

    // pads leave reset already in the reset configuration
    wire logic [2:0] rst_pull = rst_pin_config[pos_pull_hi:pos_pull_lo];
    wire logic rst_dir = rst_pin_config[pos_dir_sel];
    wire logic rst_addr = rst_pin_config[pos_addr_sel];

    // ------------------------------------------------------------
    // pad control registers
    // ------------------------------------------------------------
    // one flop of delay keeps decode glitches off the pads
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            analog_r <= {2{rst_pull == pull_analog}};
            pull_up_r <= {2{rst_pull == pull_up_weak}};
            pull_down_r <= {2{(rst_pull == pull_down_weak) & rst_dir}};
            oe_r <= {2{~rst_dir & (rst_pull == pull_push_pull)}};
        end
        else
        begin
            analog_r <= analog_nxt;
            pull_up_r <= pull_up_nxt;
            pull_down_r <= pull_down_nxt;
            oe_r <= oe_nxt;
        end
    end

    // address bit registered with its use
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            out_r <= 2'h0;
            addr_use_r <= {2{rst_addr}};
            addr_bit_r <= 2'h0;
        end
        else
        begin
            out_r <= out_nxt;
            addr_use_r <= addr_use_nxt;
            addr_bit_r <= addr_bit_nxt;
        end
    end

    assign pin_one_analog = analog_r[0];
    assign pin_two_analog = analog_r[1];
    assign pin_one_pull_up = pull_up_r[0];
    assign pin_two_pull_up = pull_up_r[1];
    assign pin_one_pull_down = pull_down_r[0];
    assign pin_two_pull_down = pull_down_r[1];
    assign pin_one_oe = oe_r[0];
    assign pin_two_oe = oe_r[1];
    assign pin_one_out = out_r[0];
    assign pin_two_out = out_r[1];
    assign pin_one_addr_use = addr_use_r[0];
    assign pin_two_addr_use = addr_use_r[1];
    assign pin_one_addr_bit = addr_bit_r[0];
    assign pin_two_addr_bit = addr_bit_r[1];

    // ------------------------------------------------------------
    // pin sampling and fault compare
    // ------------------------------------------------------------
    // two-flop pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sync_a_r <= 2'h0;
            sync_b_r <= 2'h0;
        end
        else
        begin
            sync_a_r <= {pin_two_in, pin_one_in};
            sync_b_r <= sync_a_r;
        end
    end

    // fault level select; reserved 11 never faults
    wire logic flt_one_nxt = (flt_one == fault_on_low) ? ~sync_b_r[0] :
                             (flt_one == fault_on_high) ? sync_b_r[0] :
                             1'b0;
    wire logic flt_two_nxt = (flt_two == fault_on_low) ? ~sync_b_r[1] :
                             (flt_two == fault_on_high) ? sync_b_r[1] :
                             1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            fault_r <= 2'h0;
            fault_q_r <= 2'h0;
        end
        else
        begin
            fault_r <= {flt_two_nxt, flt_one_nxt};
            fault_q_r <= fault_r;
        end
    end

    assign fault_pin_one = fault_r[0];
    assign fault_pin_two = fault_r[1];

    // ------------------------------------------------------------
    // interrupt: sticky on fault rising edge, set beats clear
    // ------------------------------------------------------------
    wire logic [1:0] irq_set = fault_r & ~fault_q_r;
    wire logic [1:0] irq_clr = wr_clr ? hwdata[1:0] : 2'h0;
    wire logic [1:0] irq_status_nxt = irq_set | (irq_status_r & ~irq_clr);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            irq_status_r <= 2'h0;
            irq_enable_r <= rst_irq_enable;
        end
        else
        begin
            irq_status_r <= irq_status_nxt;
            if (wr_en)
                irq_enable_r <= hwdata[1:0];
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);

endmodule
`default_nettype wire

// ==== verilog/pin_config_pkg.sv ====
/*
 pin_config_pkg: register offsets, field positions, reset values and
 code points of the general pin configuration block.
 assumes: included ahead of pin_config.sv.
*/
package pin_config_pkg;

    // ------------------------------------------------------------
    // register byte addresses (index times four)
    // ------------------------------------------------------------
    localparam logic [7:0] idx_pin_one_config = 8'h2f;
    localparam logic [7:0] idx_pin_two_config = 8'h30;
    localparam logic [9:0] adr_pin_one_config = {idx_pin_one_config, 2'b00};
    localparam logic [9:0] adr_pin_two_config = {idx_pin_two_config, 2'b00};
    localparam logic [9:0] adr_irq_status = 10'h100;
    localparam logic [9:0] adr_irq_enable = 10'h104;
    localparam logic [9:0] adr_irq_clear = 10'h108;
    localparam logic [9:0] adr_pin_status = 10'h10c;

    // ------------------------------------------------------------
    // field positions of a pin configuration register
    // ------------------------------------------------------------
    localparam int pos_addr_sel = 6;
    localparam int pos_dir_sel = 5;
    localparam int pos_pull_hi = 4;
    localparam int pos_pull_lo = 2;
    localparam int pos_fault_hi = 1;
    localparam int pos_fault_lo = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] rst_pin_config = 8'h30;
    localparam logic [1:0] rst_irq_enable = 2'h0;

    // ------------------------------------------------------------
    // code points
    // ------------------------------------------------------------
    localparam logic [2:0] pull_analog = 3'h0;
    localparam logic [2:0] pull_up_weak = 3'h2;
    localparam logic [2:0] pull_down_weak = 3'h4;
    localparam logic [2:0] pull_push_pull = 3'h5;
    localparam logic [1:0] fault_never = 2'h0;
    localparam logic [1:0] fault_on_low = 2'h1;
    localparam logic [1:0] fault_on_high = 2'h2;

    // ahb-lite transfer types
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [1:0] htrans_seq = 2'h3;

endpackage

// ==== dv/pin_config_checker.sv ====
/* pin_config_checker: port assertions on pin_config.
 assumes: bound to pin_config; one clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none
module pin_config_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // pads
    input wire logic pin_one_in,
    input wire logic pin_two_in,
    input wire logic pin_one_out,
    input wire logic pin_two_out,
    input wire logic pin_one_oe,
    input wire logic pin_two_oe,
    input wire logic pin_one_pull_up,
    input wire logic pin_two_pull_up,
    input wire logic pin_one_pull_down,
    input wire logic pin_two_pull_down,
    input wire logic pin_one_analog,
    input wire logic pin_two_analog,
    input wire logic pin_one_addr_use,
    input wire logic pin_two_addr_use,
    input wire logic pin_one_drive,
    input wire logic pin_two_drive,
    input wire logic pin_one_addr_bit,
    input wire logic pin_two_addr_bit,
    // faults
    input wire logic fault_pin_one,
    input wire logic fault_pin_two,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // three stable samples span the sync flops and the output flop
    sequence held_one;
        (pin_one_addr_use && $stable(pin_one_in))[*3];
    endsequence
    sequence held_two;
        (pin_two_addr_use && $stable(pin_two_in))[*3];
    endsequence
    pulls_one_a: assert property (
        $onehot0({pin_one_oe, pin_one_pull_up, pin_one_pull_down,
        pin_one_analog})) else $error("pin one pulls");
    pulls_two_a: assert property (
        $onehot0({pin_two_oe, pin_two_pull_up, pin_two_pull_down,
        pin_two_analog})) else $error("pin two pulls");
    drive_one_a: assert property (
        pin_one_out == ($past(pin_one_drive) && pin_one_oe))
        else $error("pin one drive");
    drive_two_a: assert property (
        pin_two_out == ($past(pin_two_drive) && pin_two_oe))
        else $error("pin two drive");
    addr_one_a: assert property (
        held_one |-> pin_one_addr_bit == pin_one_in)
        else $error("pin one address");
    addr_two_a: assert property (
        held_two |-> pin_two_addr_bit == pin_two_in)
        else $error("pin two address");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer");
    reset_state_a: assert property (
        $fell(reset) |-> !fault_pin_one && !fault_pin_two && !irq &&
        !pin_one_oe && pin_two_pull_down) else $error("reset");
endmodule
bind pin_config pin_config_checker pin_config_checker_i (.*);
`default_nettype wire

// ==== dv/pin_pad_model.sv ====
/* pin_pad_model: board side of one general pin.
 assumes: ext is the level some source puts on a floating pin. */
`timescale 1ns/1ns
`default_nettype none
module pin_pad_model (
    // pad controls
    input wire logic oe,
    input wire logic out,
    input wire logic pull_up,
    input wire logic pull_down,
    // board
    input wire logic ext,
    output logic level
);
    assign level = oe ? out : pull_up ? 1'b1 : pull_down ? 1'b0 : ext;
endmodule
`default_nettype wire

// ==== dv/general_pin_config_bench.sv ====
/* general_pin_config_bench: self-checking bench of pin_config.
 assumes: pads modelled by pin_pad_model, checker bound. */
`timescale 1ns/1ns
`default_nettype none
`define chk(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module general_pin_config_bench;
    import pin_config_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, drv = 2'h0, ext = 2'h0, fm = 2'h0;
    wire logic [1:0] pin, pout, oe, pu, pd, an, au, ab, flt;
    wire logic hreadyout, hresp, irq;
    logic [7:0] lf = 8'h59, c;
    logic [9:0] ra;
    logic [2:0] pk;
    logic dr;
    logic [2:0] codes [4] = '{pull_analog, pull_up_weak, pull_down_weak,
        pull_push_pull};
    int fails = 0, checks = 0, st = 0, en = 3, cfg [2] = '{8'h30, 8'h30};
    always #10 clk_sys = ~clk_sys;
    pin_config pin_config_i (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_one_in(pin[0]),
        .pin_one_out(pout[0]), .pin_one_oe(oe[0]), .pin_one_pull_up(pu[0]),
        .pin_one_pull_down(pd[0]), .pin_one_analog(an[0]),
        .pin_one_addr_use(au[0]), .pin_two_in(pin[1]), .pin_two_out(pout[1]),
        .pin_two_oe(oe[1]), .pin_two_pull_up(pu[1]), .pin_two_pull_down(pd[1]),
        .pin_two_analog(an[1]), .pin_two_addr_use(au[1]),
        .pin_one_drive(drv[0]), .pin_two_drive(drv[1]),
        .pin_one_addr_bit(ab[0]), .pin_two_addr_bit(ab[1]),
        .fault_pin_one(flt[0]), .fault_pin_two(flt[1]), .irq(irq));
    pin_pad_model pad_one_i (.oe(oe[0]), .out(pout[0]), .pull_up(pu[0]),
        .pull_down(pd[0]), .ext(ext[0]), .level(pin[0]));
    pin_pad_model pad_two_i (.oe(oe[1]), .out(pout[1]), .pull_up(pu[1]),
        .pull_down(pd[1]), .ext(ext[1]), .level(pin[1]));
    function automatic logic [7:0] step(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic fexp(int k, logic l);
        return (k[1:0] == fault_on_low && !l) || (k[1:0] == fault_on_high && l);
    endfunction
    task automatic bus(input logic w, input logic [9:0] a, input int d,
        output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= htrans_nonseq;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [9:0] a, input int d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [9:0] a, input int e);
        logic [31:0] q;
        bus(1'b0, a, 0, q);
        `chk(q, e)
    endtask
    task automatic chkpin(input int p);
        logic [2:0] k;
        k = cfg[p][4:2];
        `chk(an[p], k == pull_analog)
        `chk(pu[p], k == pull_up_weak)
        `chk(pd[p], k == pull_down_weak && cfg[p][5])
        `chk(oe[p], k == pull_push_pull && !cfg[p][5])
        `chk(pout[p], k == pull_push_pull && !cfg[p][5] && drv[p])
        `chk(au[p], cfg[p][6])
    endtask
    // sticky status rises with each fault flag
    task automatic upd;
        logic nf;
        for (int p = 0; p < 2; p++)
        begin
            nf = fexp(cfg[p], ext[p]);
            if (nf && !fm[p]) st = st | (1 << p);
            fm[p] = nf;
        end
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        close_out;
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        rdc(adr_pin_one_config, 8'h30);
        rdc(adr_pin_two_config, 8'h30);
        chkpin(0);
        chkpin(1);
        wr(10'h200, 8'hff);
        rdc(10'h200, 0);
        wr(adr_irq_enable, en);
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            lf = step(lf);
            pk = codes[i % 4];
            dr = pk == pull_down_weak ? 1'b1 : pk == pull_push_pull ? 1'b0 :
                i[2] ^ i[3];
            c = {1'b1, lf[6], dr, pk, 2'h0};
            ra = i[0] ? adr_pin_two_config : adr_pin_one_config;
            wr(ra, c);
            cfg[i % 2] = {24'h0, 1'b0, c[6:0]};
            drv <= lf[1:0];
            repeat (2) @(posedge clk_sys);
            chkpin(i % 2);
            rdc(ra, cfg[i % 2]);
        end
        $display("test pulls done");
        // pins settle on ext first, so later writes never move a pin
        for (int p = 0; p < 2; p++)
        begin
            c = {2'h0, 1'b1, pull_analog, fault_never};
            wr(p ? adr_pin_two_config : adr_pin_one_config, c);
            cfg[p] = c;
        end
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 12; i++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                lf = step(lf);
                c = {1'b0, lf[6], 1'b1, pull_analog,
                    (lf[1:0] == 2'h3) ? fault_on_low : lf[1:0]};
                wr(p ? adr_pin_two_config : adr_pin_one_config, c);
                cfg[p] = c;
                repeat (4) @(posedge clk_sys);
                upd;
            end
            ext <= lf[3:2];
            repeat (4) @(posedge clk_sys);
            upd;
            `chk(flt, {fexp(cfg[1], ext[1]), fexp(cfg[0], ext[0])})
            `chk(ab, {cfg[1][6] & ext[1], cfg[0][6] & ext[0]})
            rdc(adr_irq_status, st);
            rdc(adr_pin_status, {fexp(cfg[1], ext[1]),
                fexp(cfg[0], ext[0]), ext});
            `chk(irq, |(st & en))
            if (i[0]) wr(adr_irq_clear, 3);
            if (i[0]) st = 0;
            if (i % 4 == 2) en = lf[5:4];
            if (i % 4 == 2) wr(adr_irq_enable, en);
        end
        $display("test faults done");
        close_out;
    end
endmodule
`default_nettype wire
